// file: logic/icd_pkg.sv
// Constants, types and encodings shared by the instruction-cycle decoder.
// Assumes a 24-bit program word, a 125 MHz core clock and a Wishbone slave port.
//
// Summary of operation
// - Double-word instruction spans 48 bits; second word's upper 8 bits are zero.
// - A lone second word, upper 8 bits zero, decodes as a no-operation.
// - Every double-word instruction takes exactly two cycles.
// - Single-word takes one cycle; two when condition true or PC changes.
// - Jumps, indirect calls, table accesses and returns take two or three cycles.
// - Skip takes two cycles over single-word, three over two-word instruction.
// - A double-word data move takes two cycles.
// - Sixteen working registers, zero to fifteen, as base, source or destination.
// - File-register ops defaulting to the working register use register zero.
// - Accumulator write-back goes to register thirteen or its target, post-increment two.
// - X prefetch uses reg 8 or 9 with modify, reg 9 plus 12, or none.
// - Y prefetch uses reg 10 or 11 with modify, reg 11 plus 12, or none.
// - X and Y prefetch destinations are working registers four to seven.
// - Multiply operands are one of six distinct pairs from registers four to seven.
// - Square multiplies one of registers four to seven by itself.
// - Divide takes dividend and divisor from a register pair, direct addressing only.
// - Bit position is a 4-bit field selecting bit 0 to 15.
// - Ten-bit literal limited to 0..255 in byte mode, 0..1023 in word mode.
// - Accumulator operand selects exactly one of two accumulators, A or B.
// - Core keeps carry, digit carry, negative, overflow and sticky zero flags.
// - Core keeps overflow and saturation flags for accumulators A and B.
// - Single-word instruction is 24 bits with an 8-bit opcode field.

`default_nettype none

package icd_pkg;

  // Instruction word layout
  localparam int          WORD_W      = 24;
  localparam int          OPC_MSB     = 23;
  localparam int          OPC_LSB     = 16;

  // Opcode classes
  localparam logic [7:0]  OPC_NOP     = 8'h00;
  localparam logic [7:0]  OPC_DWORD   = 8'h01;
  localparam logic [7:0]  OPC_MOVD    = 8'h02;
  localparam logic [7:0]  OPC_BRCOND  = 8'h03;
  localparam logic [7:0]  OPC_JUMP    = 8'h04;
  localparam logic [7:0]  OPC_CALLIND = 8'h05;
  localparam logic [7:0]  OPC_TABLE   = 8'h06;
  localparam logic [7:0]  OPC_RETURN  = 8'h07;
  localparam logic [7:0]  OPC_IRET    = 8'h08;
  localparam logic [7:0]  OPC_SKIP    = 8'h09;
  localparam logic [7:0]  OPC_SQR     = 8'h0c;
  localparam logic [7:0]  OPC_DIV     = 8'h0d;
  localparam logic [7:0]  OPC_BIT     = 8'h0e;
  localparam logic [7:0]  OPC_TEN_BIT_LITERAL   = 8'h0f;
  localparam logic [7:0]  OPC_FILE    = 8'h14;
  localparam logic [5:0]  OPC_MAC_HI  = 6'h04;   // 8'h10..8'h13: bit0 acc, bit1 write-back

  // Cycle counts
  localparam logic [1:0]  CYC_ONE     = 2'h1;
  localparam logic [1:0]  CYC_TWO     = 2'h2;
  localparam logic [1:0]  CYC_THREE   = 2'h3;

  // Fixed register numbers
  localparam logic [3:0]  REG_W0      = 4'h0;
  localparam logic [3:0]  REG_W4      = 4'h4;
  localparam logic [3:0]  REG_W8      = 4'h8;
  localparam logic [3:0]  REG_W9      = 4'h9;
  localparam logic [3:0]  REG_W10     = 4'ha;
  localparam logic [3:0]  REG_W11     = 4'hb;
  localparam logic [3:0]  REG_W12     = 4'hc;
  localparam logic [3:0]  REG_W13     = 4'hd;
  localparam logic [3:0]  AWB_INC     = 4'h2;
  localparam logic [3:0]  PF_IDX_CODE = 4'he;
  localparam logic [3:0]  PF_NONE     = 4'hf;
  localparam logic [9:0]  LIT_BYTE_MAX = 10'h0ff;

  // Wishbone register byte offsets
  localparam logic [3:0]  ADR_FLAGS   = 4'h0;
  localparam logic [3:0]  ADR_CTRL    = 4'h4;
  localparam logic [3:0]  ADR_INFO    = 4'h8;
  localparam logic        CTRL_RST    = 1'b1;
  localparam int          CTRL_EN_BIT = 0;
  // Flag register bit positions
  localparam int          FB_C  = 0;
  localparam int          FB_DC = 1;
  localparam int          FB_N  = 2;
  localparam int          FB_OV = 3;
  localparam int          FB_Z  = 4;
  localparam int          FB_OA = 8;
  localparam int          FB_OB = 9;
  localparam int          FB_SA = 10;
  localparam int          FB_SB = 11;

  typedef enum logic [1:0] {
    ICD_ST_ACCEPT = 2'b00,
    ICD_ST_WORD2  = 2'b01,
    ICD_ST_FILL   = 2'b10
  } icd_state_t;

  // One prefetch operand
  typedef struct packed {
    logic             en;
    logic             idx;
    logic [3:0]       addr;
    logic signed [3:0] mod;
  } icd_pf_t;

  // Decoded instruction handed to the execute stage
  typedef struct packed {
    logic [7:0]  opcode;
    logic [1:0]  cycles;
    logic [3:0]  wb;
    logic [3:0]  ws;
    logic [3:0]  wd;
    logic        acc_b;
    icd_pf_t     xpf;
    icd_pf_t     ypf;
    logic [3:0]  xd;
    logic [3:0]  yd;
    logic [3:0]  mul_a;
    logic [3:0]  mul_b;
    logic        awb_en;
    logic        awb_ind;
    logic [3:0]  bit_position_field;
    logic [9:0]  ten_bit_literal;
    logic        byte_mode;
    logic [12:0] file_addr;
    logic        to_file_op_default_work_reg;
    logic [23:0] ext_literal;
    logic        illegal;
  } icd_dec_t;

  // Flag update from the execute stage
  typedef struct packed {
    logic mcu_we;
    logic dsp_we;
    logic z_sticky;
    logic c;
    logic digit_carry_flag;
    logic n;
    logic signed_range_exceeded_flag;
    logic z;
    logic accum_a_overflow;
    logic accum_b_overflow;
    logic accum_a_clipped;
    logic accum_b_clipped;
  } icd_flag_upd_t;

endpackage

`default_nettype wire

// file: logic/icd_decoder.sv
// Decode stage: cycle counting, operand decode, status flags, Wishbone registers.
// Assumes fetch presents words with valid/ready, execute reports condition and
// skip outcomes in the same cycle, and everything runs on clk_i.

`default_nettype none

module icd_decoder (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Fetch side
  input  wire logic                   word_valid_i,
  input  wire logic [23:0]            word_i,
  output logic                        word_ready_o,
  // Execute side outcomes for the current word
  input  wire logic                   cond_true_i,
  input  wire logic                   next_two_word_i,
  input  wire icd_pkg::icd_flag_upd_t flag_upd_i,
  output icd_pkg::icd_dec_t           dec_o,
  output logic                        dec_valid_o,
  output logic                        nop_fill_o,
  output logic [1:0]                  cycle_count_o,
  output logic [15:0]                 flags_o,
  // Wishbone classic slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [3:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic [31:0]                 dat_o,
  output logic                        ack_o
);

  icd_pkg::icd_state_t state_reg;
  icd_pkg::icd_state_t state_next;
  logic [1:0]          fill_reg;
  logic [23:0]         word1_reg;
  logic                ctrl_en_reg;
  logic [15:0]         flags_reg;
  logic [15:0]         retired_reg;
  logic                illegal_seen_reg;
  icd_pkg::icd_dec_t   dec_reg;
  logic                dec_valid_reg;
  logic                fill_out_reg;
  logic [31:0]         rdat_reg;
  logic                ack_reg;
  icd_pkg::icd_dec_t   dec_single;
  logic [7:0]          opc;
  logic                take;
  logic                wb_req;
  logic                wb_wr;

  // Prefetch decode: codes 0-6 low register, 7-13 high, 14 indexed, 15 none
  function automatic icd_pkg::icd_pf_t pf_decode(input logic [3:0] code,
                                                 input logic [3:0] lo,
                                                 input logic [3:0] hi);
    icd_pkg::icd_pf_t p;
    logic [2:0]       m;
    p      = '0;
    m      = (code >= 4'h7) ? 3'(code - 4'h7) : code[2:0];
    p.en   = (code != icd_pkg::PF_NONE);
    p.idx  = (code == icd_pkg::PF_IDX_CODE);
    p.addr = (code >= 4'h7) ? hi : lo;
    case (m)
      3'h0:    p.mod = 4'sh6;
      3'h1:    p.mod = 4'sh4;
      3'h2:    p.mod = 4'sh2;
      3'h4:    p.mod = -4'sh6;
      3'h5:    p.mod = -4'sh4;
      3'h6:    p.mod = -4'sh2;
      default: p.mod = 4'sh0;
    endcase
    if (p.idx || !p.en) begin
      p.mod = 4'sh0;
    end
    return p;
  endfunction

  assign opc  = word_i[icd_pkg::OPC_MSB:icd_pkg::OPC_LSB];
  assign take = word_valid_i && word_ready_o;

  // Single-word operand and cycle decode
  always_comb begin
    dec_single        = '0;
    dec_single.opcode = ctrl_en_reg ? opc : icd_pkg::OPC_NOP;
    dec_single.cycles = icd_pkg::CYC_ONE;
    // Generic three-register form, any of W0..W15
    dec_single.wd     = word_i[3:0];
    dec_single.ws     = word_i[7:4];
    dec_single.wb     = word_i[11:8];
    if (ctrl_en_reg) begin
      case (opc)
        // Lone second word or true NOP: one cycle, no effect
        icd_pkg::OPC_NOP: begin
          dec_single.wd = '0;
          dec_single.ws = '0;
          dec_single.wb = '0;
        end
        icd_pkg::OPC_DWORD:   dec_single.cycles = icd_pkg::CYC_TWO;
        icd_pkg::OPC_MOVD:    dec_single.cycles = icd_pkg::CYC_TWO;
        icd_pkg::OPC_BRCOND: begin
          dec_single.cycles = cond_true_i ? icd_pkg::CYC_TWO : icd_pkg::CYC_ONE;
        end
        icd_pkg::OPC_JUMP,
        icd_pkg::OPC_CALLIND,
        icd_pkg::OPC_TABLE:   dec_single.cycles = icd_pkg::CYC_TWO;
        icd_pkg::OPC_RETURN,
        icd_pkg::OPC_IRET:    dec_single.cycles = icd_pkg::CYC_THREE;
        icd_pkg::OPC_SKIP: begin
          if (cond_true_i) begin
            dec_single.cycles = next_two_word_i ? icd_pkg::CYC_THREE : icd_pkg::CYC_TWO;
          end
        end
        icd_pkg::OPC_SQR: begin
          dec_single.mul_a = icd_pkg::REG_W4 + {2'h0, word_i[1:0]};
          dec_single.mul_b = icd_pkg::REG_W4 + {2'h0, word_i[1:0]};
        end
        icd_pkg::OPC_DIV: begin
          // Register numbers only: no address modifier is decoded
          dec_single.ws = word_i[7:4];
          dec_single.wb = word_i[3:0];
          dec_single.wd = '0;
        end
        icd_pkg::OPC_BIT: begin
          dec_single.bit_position_field = word_i[15:12];
          dec_single.ws = word_i[3:0];
        end
        icd_pkg::OPC_TEN_BIT_LITERAL: begin
          dec_single.byte_mode = word_i[14];
          dec_single.ten_bit_literal = word_i[13:4];
          // Byte mode keeps the low eight bits and flags the overrun
          if (word_i[14] && (word_i[13:4] > icd_pkg::LIT_BYTE_MAX)) begin
            dec_single.ten_bit_literal = {2'h0, word_i[11:4]};
            dec_single.illegal = 1'b1;
          end
        end
        icd_pkg::OPC_FILE: begin
          dec_single.file_addr = word_i[12:0];
          dec_single.to_file_op_default_work_reg   = word_i[13];
          dec_single.wd        = icd_pkg::REG_W0;
          dec_single.ws        = '0;
          dec_single.wb        = '0;
        end
        default: begin
          if (opc[7:2] == icd_pkg::OPC_MAC_HI) begin
            dec_single.acc_b   = opc[0];
            dec_single.awb_en  = opc[1];
            dec_single.awb_ind = word_i[15];
            dec_single.wd      = icd_pkg::REG_W13;
            dec_single.wb      = word_i[15] ? icd_pkg::AWB_INC : '0;
            dec_single.ws      = '0;
            // Six distinct pairs; codes 6 and 7 are rejected
            case (word_i[14:12])
              3'h0:    {dec_single.mul_a, dec_single.mul_b} = {4'h4, 4'h5};
              3'h1:    {dec_single.mul_a, dec_single.mul_b} = {4'h4, 4'h6};
              3'h2:    {dec_single.mul_a, dec_single.mul_b} = {4'h4, 4'h7};
              3'h3:    {dec_single.mul_a, dec_single.mul_b} = {4'h5, 4'h6};
              3'h4:    {dec_single.mul_a, dec_single.mul_b} = {4'h5, 4'h7};
              3'h5:    {dec_single.mul_a, dec_single.mul_b} = {4'h6, 4'h7};
              default: dec_single.illegal = 1'b1;
            endcase
            dec_single.xpf = pf_decode(word_i[11:8], icd_pkg::REG_W8, icd_pkg::REG_W9);
            dec_single.ypf = pf_decode(word_i[7:4], icd_pkg::REG_W10, icd_pkg::REG_W11);
            dec_single.xd  = icd_pkg::REG_W4 + {2'h0, word_i[3:2]};
            dec_single.yd  = icd_pkg::REG_W4 + {2'h0, word_i[1:0]};
          end
        end
      endcase
    end
  end

  // Sequencer: second word capture and filler insertion
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      icd_pkg::ICD_ST_ACCEPT: begin
        if (take && ctrl_en_reg && (opc == icd_pkg::OPC_DWORD)) begin
          state_next = icd_pkg::ICD_ST_WORD2;
        end else if (take && (dec_single.cycles != icd_pkg::CYC_ONE)) begin
          state_next = icd_pkg::ICD_ST_FILL;
        end
      end
      icd_pkg::ICD_ST_WORD2: begin
        if (take) begin
          state_next = icd_pkg::ICD_ST_ACCEPT;
        end
      end
      icd_pkg::ICD_ST_FILL: begin
        if (fill_reg == 2'h1) begin
          state_next = icd_pkg::ICD_ST_ACCEPT;
        end
      end
      default: state_next = icd_pkg::ICD_ST_ACCEPT;
    endcase
  end

  // Fetch stalls only while filler cycles run
  assign word_ready_o = (state_reg != icd_pkg::ICD_ST_FILL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= icd_pkg::ICD_ST_ACCEPT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Filler counter: cycles beyond the first become no-operations
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_reg <= 2'h0;
    end else if (state_reg == icd_pkg::ICD_ST_ACCEPT && state_next == icd_pkg::ICD_ST_FILL) begin
      fill_reg <= 2'(dec_single.cycles - 2'h1);
    end else if (fill_reg != 2'h0) begin
      fill_reg <= 2'(fill_reg - 2'h1);
    end
  end

  // First word is held until its partner arrives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word1_reg <= 24'h000000;
    end else if (take && state_reg == icd_pkg::ICD_ST_ACCEPT) begin
      word1_reg <= word_i;
    end
  end

  // Decoded output; the first word of a pair emits nothing until the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_reg       <= '0;
      dec_valid_reg <= 1'b0;
      fill_out_reg  <= 1'b0;
    end else begin
      dec_valid_reg <= 1'b0;
      fill_out_reg  <= (state_reg == icd_pkg::ICD_ST_FILL);
      if (take && state_reg == icd_pkg::ICD_ST_WORD2) begin
        dec_reg             <= '0;
        dec_reg.opcode      <= icd_pkg::OPC_DWORD;
        dec_reg.cycles      <= icd_pkg::CYC_TWO;
        dec_reg.ext_literal <= {word_i[15:0], word1_reg[7:0]};
        dec_reg.wd          <= word1_reg[11:8];
        // Nonzero upper byte in the second word is malformed
        dec_reg.illegal     <= (word_i[icd_pkg::OPC_MSB:icd_pkg::OPC_LSB] != 8'h00);
        dec_valid_reg       <= 1'b1;
      end else if (take && !(ctrl_en_reg && opc == icd_pkg::OPC_DWORD)) begin
        dec_reg       <= dec_single;
        dec_valid_reg <= 1'b1;
      end
    end
  end

  // Status flags: execute update wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= 16'h0000;
    end else begin
      if (wb_wr && adr_i == icd_pkg::ADR_FLAGS) begin
        if (sel_i[0]) begin
          flags_reg[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          flags_reg[15:8] <= dat_i[15:8];
        end
      end
      if (flag_upd_i.mcu_we) begin
        flags_reg[icd_pkg::FB_C]  <= flag_upd_i.c;
        flags_reg[icd_pkg::FB_DC] <= flag_upd_i.digit_carry_flag;
        flags_reg[icd_pkg::FB_N]  <= flag_upd_i.n;
        flags_reg[icd_pkg::FB_OV] <= flag_upd_i.signed_range_exceeded_flag;
        // Sticky zero only ever clears across a multi-word sequence
        flags_reg[icd_pkg::FB_Z]  <= flag_upd_i.z_sticky ? (flags_reg[icd_pkg::FB_Z] & flag_upd_i.z)
                                                         : flag_upd_i.z;
      end
      if (flag_upd_i.dsp_we) begin
        flags_reg[icd_pkg::FB_OA] <= flag_upd_i.accum_a_overflow;
        flags_reg[icd_pkg::FB_OB] <= flag_upd_i.accum_b_overflow;
        flags_reg[icd_pkg::FB_SA] <= flag_upd_i.accum_a_clipped;
        flags_reg[icd_pkg::FB_SB] <= flag_upd_i.accum_b_clipped;
      end
      flags_reg[7:5]   <= 3'h0;
      flags_reg[15:12] <= 4'h0;
    end
  end

  // Control: decode enable, else every word runs as a no-operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en_reg <= icd_pkg::CTRL_RST;
    end else if (wb_wr && adr_i == icd_pkg::ADR_CTRL && sel_i[0]) begin
      ctrl_en_reg <= dat_i[icd_pkg::CTRL_EN_BIT];
    end
  end

  // Retired-instruction count and sticky malformed-word flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retired_reg      <= 16'h0000;
      illegal_seen_reg <= 1'b0;
    end else begin
      if (dec_valid_reg) begin
        retired_reg <= 16'(retired_reg + 16'h0001);
      end
      // Set wins over the write-one-to-clear
      if (dec_valid_reg && dec_reg.illegal) begin
        illegal_seen_reg <= 1'b1;
      end else if (wb_wr && adr_i == icd_pkg::ADR_INFO && sel_i[2] && dat_i[16]) begin
        illegal_seen_reg <= 1'b0;
      end
    end
  end

  // Wishbone: one-cycle registered ack, unmapped addresses read zero
  assign wb_req = cyc_i && stb_i && !ack_reg;
  assign wb_wr  = wb_req && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          icd_pkg::ADR_FLAGS: rdat_reg <= {16'h0000, flags_reg};
          icd_pkg::ADR_CTRL:  rdat_reg <= {31'h00000000, ctrl_en_reg};
          icd_pkg::ADR_INFO:  rdat_reg <= {13'h0000, state_reg, illegal_seen_reg, retired_reg};
          default:            rdat_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign dat_o         = rdat_reg;
  assign ack_o         = ack_reg;
  assign dec_o         = dec_reg;
  assign dec_valid_o   = dec_valid_reg;
  assign nop_fill_o    = fill_out_reg;
  assign cycle_count_o = dec_reg.cycles;
  assign flags_o       = flags_reg;

endmodule

`default_nettype wire

// file: tb/icd_decoder_checker.sv
// Checker for the decoder: cycle counts, filler timing and the bus answer.
// Assumes it is bound to icd_decoder and sees only that module's ports.
`default_nettype none
module icd_decoder_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        word_valid_i,
  input wire logic [23:0] word_i,
  input wire logic        word_ready_o,
  input wire logic        cond_true_i,
  input wire logic        next_two_word_i,
  input wire logic        dec_valid_o,
  input wire logic        nop_fill_o,
  input wire logic [1:0]  cycle_count_o,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire       tk = word_valid_i && word_ready_o;
  wire [7:0] op = word_i[23:16];
  logic      w2_reg;
  wire       fw = tk && !w2_reg;
  // Marks the word after a double-word opcode; its opcode field means nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) w2_reg <= 1'b0;
    else if (tk) w2_reg <= (op == 8'h01) && !w2_reg;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ret_three: assert property (
    fw && (op == 8'h07 || op == 8'h08) |=> dec_valid_o && cycle_count_o == 2'h3) else $error("return count");
  a_fill_gap: assert property (
    fw && op == 8'h07 |=> !word_ready_o [*2] ##1 word_ready_o) else $error("return filler gap");
  a_jump_two: assert property (
    fw && op inside {8'h04, 8'h05, 8'h06} |=> cycle_count_o == 2'h2 && !word_ready_o ##1 word_ready_o)
    else $error("jump count");
  a_move_two: assert property (
    fw && op == 8'h02 |=> cycle_count_o == 2'h2) else $error("move count");
  a_dword_two: assert property (
    tk && w2_reg |=> dec_valid_o && cycle_count_o == 2'h2 && word_ready_o) else $error("double word count");
  a_lone_nop: assert property (
    fw && op == 8'h00 |=> dec_valid_o && cycle_count_o == 2'h1) else $error("lone second word");
  a_cond_br: assert property (
    fw && op == 8'h03 |=> cycle_count_o == ($past(cond_true_i) ? 2'h2 : 2'h1)) else $error("branch count");
  a_skip_cnt: assert property (
    fw && op == 8'h09 && cond_true_i |=> cycle_count_o == ($past(next_two_word_i) ? 2'h3 : 2'h2))
    else $error("skip count");
  a_fill_pulse: assert property (
    $fell(word_ready_o) |=> nop_fill_o) else $error("filler missing");
  a_bus_ack: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bus ack");
endmodule
bind icd_decoder icd_decoder_checker u_chk (.clk_i, .rst_i, .word_valid_i, .word_i, .word_ready_o, .cond_true_i,
  .next_two_word_i, .dec_valid_o, .nop_fill_o, .cycle_count_o, .cyc_i, .stb_i, .ack_o);
`default_nettype wire

// file: tb/icd_fetch_model.sv
// Fetch and execute side model: offers one word with its outcome bits.
// Assumes a one-cycle request from the bench; released lines show inverted data.
`default_nettype none
module icd_fetch_model (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req_i,
  input wire logic [23:0] wrd_i,
  input wire logic        cnd_i,
  input wire logic        two_i,
  input wire logic        word_ready_i,
  output logic            word_valid_o,
  output logic [23:0]     word_o,
  output logic            cond_true_o,
  output logic            next_two_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Hold the offer until taken, then scramble so stale values never pass
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_valid_o <= 1'b0;
    end else if (req_i) begin
      word_valid_o <= 1'b1;
      word_o       <= wrd_i;
      cond_true_o  <= cnd_i;
      next_two_o   <= two_i;
    end else if (word_valid_o && word_ready_i) begin
      word_valid_o <= 1'b0;
      word_o       <= ~word_o;
      cond_true_o  <= ~cond_true_o;
      next_two_o   <= ~next_two_o;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: words go through the fetch model, registers over the bus.
// Assumes the package, decoder, checker and fetch model are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req, cnd, two, word_valid_i, cond_true_i, next_two_word_i, word_ready_o;
  logic cyc_i, stb_i, we_i, ack_o, dec_valid_o, nop_fill_o;
  logic [23:0] wr, word_i;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [1:0] cycle_count_o;
  logic [1:0] lcc = 2'h0;
  logic [15:0] flags_o;
  icd_pkg::icd_flag_upd_t flag_upd_i;
  icd_pkg::icd_dec_t dec_o;
  int n_errors = 0;
  int tests_run = 0;
  int nfill = 0;
  int tno = 0;
  always #4 clk_i = ~clk_i;
  icd_fetch_model u_fetch (.clk_i, .rst_i, .req_i(req), .wrd_i(wr), .cnd_i(cnd), .two_i(two),
    .word_ready_i(word_ready_o), .word_valid_o(word_valid_i), .word_o(word_i), .cond_true_o(cond_true_i),
    .next_two_o(next_two_word_i));
  icd_decoder dut (.clk_i, .rst_i, .word_valid_i, .word_i, .word_ready_o, .cond_true_i, .next_two_word_i,
    .flag_upd_i, .dec_o, .dec_valid_o, .nop_fill_o, .cycle_count_o, .flags_o, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o);
  // Last reported count and a running tally of filler cycles
  always @(posedge clk_i) begin
    if (dec_valid_o) lcc <= cycle_count_o;
    if (nop_fill_o === 1'b1) nfill <= nfill + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic lim(input int k);
    if (k >= 20) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic endt();
    tno++;
    $display("test %0d finished", tno);
  endtask
  // Offer one word, wait until taken, let fillers run out; e of zero skips counts
  task automatic go(input logic [23:0] w, input logic c, input logic t, input logic [1:0] e, input int fe);
    int k;
    int f0;
    f0 = nfill;
    @(posedge clk_i);
    req <= 1'b1;
    wr <= w;
    cnd <= c;
    two <= t;
    @(posedge clk_i);
    req <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (word_valid_i && k < 20);
    lim(k);
    repeat (4) @(negedge clk_i);
    if (e != 2'h0) begin
      chk(lcc, e);
      chk(nfill - f0, fe);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    lim(k);
  endtask
  task automatic setf(input logic [11:0] v);
    @(posedge clk_i);
    flag_upd_i <= v;
    @(posedge clk_i);
    flag_upd_i <= '0;
    @(negedge clk_i);
  endtask
  initial begin
    {req, cnd, two, cyc_i, stb_i, we_i} = '0;
    {wr, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    flag_upd_i = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Control flow counts and filler cycles
    go(24'h070000, 0, 0, 2'h3, 2);
    go(24'h080000, 0, 0, 2'h3, 2);
    for (int i = 4; i < 7; i++) go({i[7:0], 16'h0000}, 0, 0, 2'h2, 1);
    go(24'h020000, 0, 0, 2'h2, 1);
    go(24'h030000, 0, 0, 2'h1, 0);
    go(24'h030000, 1, 0, 2'h2, 1);
    go(24'h090000, 0, 1, 2'h1, 0);
    go(24'h090000, 1, 0, 2'h2, 1);
    go(24'h090000, 1, 1, 2'h3, 2);
    endt();
    // Double word, then a lone second word, then a bad second word
    go(24'h010a5c, 0, 0, 2'h0, 0);
    go(24'h00beef, 0, 0, 2'h2, 0);
    chk(dec_o.ext_literal, 24'hbeef5c);
    chk(dec_o.wd, 4'ha);
    chk(dec_o.illegal, 1'b0);
    go(24'h001234, 0, 0, 2'h1, 0);
    chk({dec_o.opcode, dec_o.wb, dec_o.ws, dec_o.wd}, 20'h0);
    go(24'h010000, 0, 0, 2'h0, 0);
    go(24'h050000, 0, 0, 2'h0, 0);
    chk(dec_o.illegal, 1'b1);
    endt();
    // Operand fields
    go(24'h0c0003, 0, 0, 2'h1, 0);
    chk({dec_o.mul_a, dec_o.mul_b}, 8'h77);
    go(24'h13defc, 0, 0, 2'h1, 0);
    chk({dec_o.mul_a, dec_o.mul_b}, 8'h67);
    chk(dec_o.acc_b, 1'b1);
    chk({dec_o.awb_ind, dec_o.wd, dec_o.wb}, 9'h1d2);
    chk({dec_o.xpf.en, dec_o.xpf.idx, dec_o.xpf.addr}, 6'h39);
    chk(dec_o.ypf.en, 1'b0);
    chk({dec_o.xd, dec_o.yd}, 8'h74);
    go(24'h1001c0, 0, 0, 2'h1, 0);
    chk({dec_o.xpf.addr, dec_o.xpf.mod, dec_o.ypf.addr, dec_o.ypf.mod}, 16'h84bc);
    go(24'h106000, 0, 0, 2'h1, 0);
    chk(dec_o.illegal, 1'b1);
    go(24'h0f5ff3, 0, 0, 2'h1, 0);
    chk({dec_o.illegal, dec_o.ten_bit_literal}, 11'h4ff);
    go(24'h0f3ff5, 0, 0, 2'h1, 0);
    chk({dec_o.illegal, dec_o.ten_bit_literal}, 11'h3ff);
    go(24'h142abc, 0, 0, 2'h1, 0);
    chk({dec_o.wd, dec_o.file_addr}, 17'h00abc);
    go(24'h0ef003, 0, 0, 2'h1, 0);
    chk(dec_o.bit_position_field, 4'hf);
    go(24'h0d00a3, 0, 0, 2'h1, 0);
    chk({dec_o.ws, dec_o.wb}, 8'ha3);
    go(24'h200f0f, 0, 0, 2'h1, 0);
    chk({dec_o.opcode, dec_o.wb, dec_o.ws, dec_o.wd}, 20'h20f0f);
    endt();
    // Status flags, sticky zero, then the register bus
    setf(12'hdff);
    chk(flags_o, 16'h0f1f);
    setf(12'hbe0);
    chk(flags_o, 16'h0f0f);
    setf(12'hbf0);
    chk(flags_o, 16'h0f0f);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0f0f);
    wb(1'b1, 4'h0, 32'h0, q);
    wb(1'b0, 4'h0, 32'h1, q);
    chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h1);
    // Decode off: every word runs as a one-cycle no-operation
    wb(1'b1, 4'h4, 32'h0, q);
    go(24'h0c0003, 0, 0, 2'h1, 0);
    chk({dec_o.opcode, dec_o.mul_a, dec_o.mul_b}, 16'h0);
    wb(1'b1, 4'h4, 32'h1, q);
    // Twenty-five decodes so far, malformed word seen, then cleared
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h00010019);
    wb(1'b1, 4'h8, 32'h00010000, q);
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h19);
    wb(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    endt();
    close_out();
  end
endmodule
`default_nettype wire
